/* File: reading_average_filter_config.sv */
// Averaging filter for readings with its measurement configuration.
`timescale 1ns/1ns
`include "reading_filter_consts.svh"
// How it works
// [RULE1] Sliding mode keeps the last depth readings; each new one displaces the oldest.
// [RULE2] Sliding mode emits the mean of the store for every new reading.
// [RULE3] An empty sliding store is filled whole by the first reading.
// [RULE4] Block mode gathers depth readings, emits their mean, then starts empty.
// [RULE5] Depth accepts only two through one hundred; other writes are refused.
// [RULE6] Diode, continuity, frequency and period bypass the filter always.
// [RULE7] Reset leaves the filter enabled, sliding, depth ten.
// [RULE8] A toggle inverts the enable; the indicator follows the enable.
// [RULE9] Bandwidth choice acts only on AC functions.
// [RULE10] Bandwidth offers slow, medium and fast, nothing else.
// [RULE11] AC readings wait 7 s, 1 s or 0.1 s settling by bandwidth.
// [RULE12] Bandwidth resets to medium; the choice is not kept.
// [RULE13] Resolution is one of six fast or slow digit choices.
// [RULE14] Each function keeps its own resolution, used for its math.
// [RULE15] Resolution resets to slow 5.5 at power-up and interface reset.
// [RULE16] AC converts at 6.5 digits; lower choices only blank digits.
// [RULE17] The digits key steps slow 4.5, slow 5.5, fast 6.5, around.
// [RULE18] Frequency and period allow only slow resolution choices.
// [RULE19] High input resistance exists only on the three lowest DC ranges.
// [RULE20] Auto impedance, off by default, picks high resistance there.
// [RULE21] Mode, depth, enable or function changes clear the store.
module reading_average_filter_config #(
  parameter int W = 24,
  parameter int DMAX = 100,
  parameter int SLOW_CYC = `MS_TO_CYC(`SETTLE_SLOW_MS),
  parameter int MED_CYC = `MS_TO_CYC(`SETTLE_MED_MS),
  parameter int FAST_CYC = `MS_TO_CYC(`SETTLE_FAST_MS)
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic signed [W-1:0] in_data,
  output logic out_valid,
  output logic signed [W-1:0] out_data,
  output logic filter_active_indicator,
  output reading_filter_pkg::func_t func,
  output logic [2:0] range_sel,
  output reading_filter_pkg::res_t conv_res,
  output reading_filter_pkg::res_t disp_res,
  output reading_filter_pkg::bw_t ac_bw,
  output logic ac_bw_apply,
  output logic high_z_sel
);
  import reading_filter_pkg::*;
  localparam int SW = W + 8;
  function automatic logic is_ac(input func_t f);
    is_ac = (f == ac_voltage_function) || (f == ac_current_function);
  endfunction
  function automatic logic is_fp(input func_t f);
    is_fp = (f == freq_function) || (f == period_function);
  endfunction
  function automatic logic res_ok(input func_t f, input logic [2:0] v);
    res_ok = (v <= 3'(slow_6d5)) && !(is_fp(f) && !v[0]);
  endfunction
  logic en_r, autoz_r;
  avg_mode_t mode_r;
  logic [6:0] depth_r;
  func_t func_r;
  logic [2:0] range_r;
  bw_t bw_r;
  res_t res_r [`N_FUNC];
  logic aw_h_r, w_h_r, bvalid_r, rvalid_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  assign s_axi_awready = !aw_h_r && !bvalid_r && ce;
  assign s_axi_wready = !w_h_r && !bvalid_r && ce;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r && ce;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  wire wr_do = aw_h_r && w_h_r && !bvalid_r && ce;
  wire wr_lane = wstrb_r[0];
  wire [6:0] wr_depth = wdata_r[6:0];
  wire func_t wr_func = func_t'(wdata_r[3:0]);
  wire [2:0] wr_res = wdata_r[2:0];
  wire sel_ctrl = awaddr_r == `OFS_CTRL;
  wire sel_depth = awaddr_r == `OFS_DEPTH;
  wire sel_func = awaddr_r == `OFS_FUNC;
  wire sel_bw = awaddr_r == `OFS_BW;
  wire sel_res = awaddr_r == `OFS_RES;
  wire depth_ok = wr_depth >= `DEPTH_MIN && wr_depth <= `DEPTH_MAX;
  wire func_ok = wdata_r[3:0] < 4'(`N_FUNC);
  wire bw_ok = wdata_r[1:0] <= 2'(bw_fast);
  logic wr_err;
  always_comb begin
    if (sel_ctrl) begin
      wr_err = 1'b0;
    end else if (sel_depth) begin
      wr_err = !depth_ok; // [RULE5]
    end else if (sel_func) begin
      wr_err = !func_ok;
    end else if (sel_bw) begin
      wr_err = !bw_ok; // [RULE10]
    end else if (sel_res) begin
      wr_err = !res_ok(func_r, wr_res); // [RULE13] [RULE18]
    end else begin
      wr_err = 1'b1;
    end
  end
  wire wr_ok = wr_do && wr_lane && !wr_err;
  wire toggle = wr_ok && sel_ctrl && wdata_r[`CTRL_TOGGLE];
  wire ifrst = wr_ok && sel_ctrl && wdata_r[`CTRL_IFRST];
  wire digits = wr_ok && sel_ctrl && wdata_r[`CTRL_DIGITS];
  // Digits key walk; slow 6.5 replaces fast 6.5 where only slow is legal.
  res_t key_next;
  always_comb begin
    case (res_r[func_r])
      slow_4d5: key_next = slow_5d5; // [RULE17]
      slow_5d5: key_next = is_fp(func_r) ? slow_6d5 : fast_6d5;
      default: key_next = slow_4d5;
    endcase
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_h_r <= 1'b0;
      w_h_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_h_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_h_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_h_r <= 1'b0;
        w_h_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_err ? 2'h2 : 2'h0;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_r <= 1'b1; // [RULE7]
      mode_r <= sliding_mean_mode;
      depth_r <= `DEPTH_RST;
      autoz_r <= 1'b0; // [RULE20]
      func_r <= dc_voltage_function;
      range_r <= 3'h0;
      bw_r <= bw_medium; // [RULE12]
    end else if (wr_ok) begin
      if (sel_ctrl) begin
        en_r <= toggle ? !en_r : wdata_r[`CTRL_EN]; // [RULE8]
        mode_r <= avg_mode_t'(wdata_r[`CTRL_MODE]);
        autoz_r <= wdata_r[`CTRL_AUTOZ];
      end else if (sel_depth) begin
        depth_r <= wr_depth;
      end else if (sel_func) begin
        func_r <= wr_func;
        range_r <= wdata_r[6:4];
      end else if (sel_bw) begin
        bw_r <= bw_t'(wdata_r[1:0]);
      end
    end
  end
  for (genvar g = 0; g < `N_FUNC; g++) begin : g_res
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        res_r[g] <= slow_5d5; // [RULE15]
      end else if (ifrst) begin
        res_r[g] <= slow_5d5; // [RULE15]
      end else if (4'(g) == func_r && wr_ok && sel_res) begin
        res_r[g] <= res_t'(wr_res); // [RULE14]
      end else if (4'(g) == func_r && digits) begin
        res_r[g] <= key_next;
      end
    end
  end
  logic pending_r;
  logic [6:0] cnt_r;
  logic signed [W-1:0] res_val_r;
  wire bypass = is_fp(func_r) || func_r == diode_function
    || func_r == cont_function || !en_r;
  logic [31:0] rd_val;
  logic rd_bad;
  always_comb begin
    rd_bad = 1'b0;
    if (s_axi_araddr == `OFS_CTRL) begin
      rd_val = {29'h0, autoz_r, mode_r, en_r};
    end else if (s_axi_araddr == `OFS_DEPTH) begin
      rd_val = {25'h0, depth_r};
    end else if (s_axi_araddr == `OFS_FUNC) begin
      rd_val = {25'h0, range_r, func_r};
    end else if (s_axi_araddr == `OFS_BW) begin
      rd_val = {30'h0, bw_r};
    end else if (s_axi_araddr == `OFS_RES) begin
      rd_val = {29'h0, res_r[func_r]};
    end else if (s_axi_araddr == `OFS_STATUS) begin
      rd_val = {17'h0, cnt_r, 4'h0, bypass, pending_r, high_z_sel, en_r};
    end else if (s_axi_araddr == `OFS_RESULT) begin
      rd_val = 32'(res_val_r);
    end else begin
      rd_val = 32'h0000_0000;
      rd_bad = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_val;
        rresp_r <= rd_bad ? 2'h2 : 2'h0;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end
  // AC readings wait out the settling time; stalling beats losing them.
  logic [31:0] settle_r;
  logic signed [W-1:0] hold_r;
  wire cur_ac = is_ac(func_r);
  wire [31:0] settle_cyc = bw_r == bw_slow ? 32'(SLOW_CYC)
    : bw_r == bw_medium ? 32'(MED_CYC) : 32'(FAST_CYC); // [RULE11]
  assign in_ready = !pending_r && ce;
  wire ac_take = in_valid && !pending_r && cur_ac && ce;
  wire fin_v = cur_ac ? (pending_r && settle_r == 32'h0) : in_valid && ce;
  wire signed [W-1:0] fin_d = cur_ac ? hold_r : in_data;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pending_r <= 1'b0;
      settle_r <= 32'h0;
      hold_r <= '0;
    end else if (ce) begin
      if (ac_take) begin
        pending_r <= 1'b1;
        hold_r <= in_data;
        settle_r <= settle_cyc - 32'h1; // [RULE11] [RULE9]
      end else if (pending_r && settle_r != 32'h0) begin
        settle_r <= settle_r - 32'h1;
      end else begin
        pending_r <= 1'b0;
      end
    end
  end
  logic signed [W-1:0] mem [DMAX];
  logic signed [SW-1:0] sum_r;
  logic [6:0] ptr_r;
  logic ov_r;
  logic [12:0] cfg_last_r;
  wire [12:0] cfg_now = {en_r, mode_r, depth_r, func_r};
  wire cfg_chg = cfg_now != cfg_last_r;
  wire signed [SW-1:0] dx = SW'(fin_d);
  wire signed [SW-1:0] old = SW'(mem[ptr_r]);
  wire signed [SW-1:0] slide_sum = sum_r + dx - old;
  wire signed [SW-1:0] blk_sum = sum_r + dx;
  wire signed [SW-1:0] dsig = SW'({1'b0, depth_r});
  wire signed [SW-1:0] slide_q = slide_sum / dsig;
  wire signed [SW-1:0] blk_q = blk_sum / dsig;
  wire last_blk = cnt_r == depth_r - 7'h1;
  wire [6:0] ptr_nxt = ptr_r == depth_r - 7'h1 ? 7'h0 : ptr_r + 7'h1;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_last_r <= {1'b1, 1'b0, `DEPTH_RST, 4'h0};
      cnt_r <= 7'h0;
      ptr_r <= 7'h0;
      sum_r <= '0;
      ov_r <= 1'b0;
      res_val_r <= '0;
    end else if (ce) begin
      cfg_last_r <= cfg_now;
      ov_r <= 1'b0;
      if (cfg_chg) begin
        cnt_r <= 7'h0; // [RULE21]
        ptr_r <= 7'h0;
        sum_r <= '0;
      end else if (fin_v && bypass) begin
        ov_r <= 1'b1; // [RULE6]
        res_val_r <= fin_d;
      end else if (fin_v && mode_r == sliding_mean_mode && cnt_r == 7'h0) begin
        for (int i = 0; i < DMAX; i++) begin
          mem[i] <= fin_d; // [RULE3]
        end
        sum_r <= SW'(dx * dsig);
        cnt_r <= depth_r;
        ov_r <= 1'b1;
        res_val_r <= fin_d;
      end else if (fin_v && mode_r == sliding_mean_mode) begin
        mem[ptr_r] <= fin_d; // [RULE1]
        ptr_r <= ptr_nxt;
        sum_r <= slide_sum;
        ov_r <= 1'b1; // [RULE2]
        res_val_r <= W'(slide_q);
      end else if (fin_v && last_blk) begin
        cnt_r <= 7'h0; // [RULE4]
        sum_r <= '0;
        ov_r <= 1'b1;
        res_val_r <= W'(blk_q);
      end else if (fin_v) begin
        cnt_r <= cnt_r + 7'h1;
        sum_r <= blk_sum;
      end
    end
  end
  assign out_valid = ov_r;
  assign out_data = res_val_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      filter_active_indicator <= 1'b1;
      func <= dc_voltage_function;
      range_sel <= 3'h0;
      conv_res <= slow_5d5;
      disp_res <= slow_5d5;
      ac_bw <= bw_medium;
      ac_bw_apply <= 1'b0;
      high_z_sel <= 1'b0;
    end else if (ce) begin
      filter_active_indicator <= en_r; // [RULE8]
      func <= func_r;
      range_sel <= range_r;
      conv_res <= cur_ac ? slow_6d5 : res_r[func_r]; // [RULE16]
      disp_res <= res_r[func_r];
      ac_bw <= bw_r;
      ac_bw_apply <= cur_ac; // [RULE9]
      high_z_sel <= autoz_r && func_r == dc_voltage_function
        && range_r < `LOWZ_RANGES; // [RULE19] [RULE20]
    end
  end
  sequence fresh_s;
    ce && fin_v && !cfg_chg && !bypass;
  endsequence
  depth_legal_a: assert property (@(posedge clk) disable iff (!resetn) // [RULE5]
    depth_r >= `DEPTH_MIN && depth_r <= `DEPTH_MAX)
    else $error("Depth left its legal range.");
  bypass_pass_a: assert property (@(posedge clk) disable iff (!resetn) // [RULE6]
    ce && fin_v && !cfg_chg && bypass |=> ov_r && res_val_r == $past(fin_d))
    else $error("Bypassed reading not passed through.");
  slide_each_a: assert property (@(posedge clk) disable iff (!resetn) // [RULE2]
    fresh_s ##0 mode_r == sliding_mean_mode |=> ov_r)
    else $error("Sliding mode missed an output.");
  fill_first_a: assert property (@(posedge clk) disable iff (!resetn) // [RULE3]
    fresh_s ##0 mode_r == sliding_mean_mode && cnt_r == 7'h0
    |=> cnt_r == depth_r && res_val_r == $past(fin_d))
    else $error("First reading did not fill the store.");
  block_quiet_a: assert property (@(posedge clk) disable iff (!resetn) // [RULE4]
    fresh_s ##0 mode_r == block_mean_mode && !last_blk
    |=> !ov_r && cnt_r == $past(cnt_r) + 7'h1)
    else $error("Block mode output before the store was full.");
  toggle_flip_a: assert property (@(posedge clk) disable iff (!resetn) // [RULE8]
    toggle |=> en_r != $past(en_r) ##1 filter_active_indicator == en_r)
    else $error("Toggle did not invert the enable.");
  ac_conv_a: assert property (@(posedge clk) disable iff (!resetn) // [RULE16]
    ce && cur_ac |=> conv_res == slow_6d5)
    else $error("AC conversion not at full digits.");
  fp_slow_a: assert property (@(posedge clk) disable iff (!resetn) // [RULE18]
    is_fp(func_r) |-> res_r[func_r][0])
    else $error("Fast resolution reached frequency or period.");
  high_z_a: assert property (@(posedge clk) disable iff (!resetn) // [RULE19]
    high_z_sel |-> $past(func_r) == dc_voltage_function
    && $past(range_r) < `LOWZ_RANGES)
    else $error("High resistance off the low DC ranges.");
  clear_chg_a: assert property (@(posedge clk) disable iff (!resetn) // [RULE21]
    ce && cfg_chg |=> cnt_r == 7'h0 && !ov_r)
    else $error("Configuration change did not clear the store.");
endmodule

/* File: reading_filter_consts.svh */
// Offsets, field positions, reset values and timing counts of the filter.
`ifndef READING_FILTER_CONSTS_SVH
`define READING_FILTER_CONSTS_SVH
`define OFS_CTRL 8'h00
`define OFS_DEPTH 8'h04
`define OFS_FUNC 8'h08
`define OFS_BW 8'h0C
`define OFS_RES 8'h10
`define OFS_STATUS 8'h14
`define OFS_RESULT 8'h18
`define CTRL_EN 0
`define CTRL_MODE 1
`define CTRL_AUTOZ 2
`define CTRL_TOGGLE 3
`define CTRL_IFRST 4
`define CTRL_DIGITS 5
`define DEPTH_MIN 7'h02
`define DEPTH_MAX 7'h64
`define DEPTH_RST 7'h0A
`define N_FUNC 11
`define LOWZ_RANGES 3'h3
`define CLK_MHZ 125
`define SETTLE_SLOW_MS 7000
`define SETTLE_MED_MS 1000
`define SETTLE_FAST_MS 100
`define MS_TO_CYC(ms) ((ms) * 1000 * `CLK_MHZ)
`endif

/* File: reading_filter_pkg.sv */
// Types shared by the reading filter and its users.
package reading_filter_pkg;
  typedef enum logic [3:0] {
    dc_voltage_function, ac_voltage_function, dc_current_function,
    ac_current_function, res2_function, res4_function, freq_function,
    period_function, diode_function, cont_function, temp_function
  } func_t;
  typedef enum logic [2:0] {
    fast_4d5, slow_4d5, fast_5d5, slow_5d5, fast_6d5, slow_6d5
  } res_t;
  typedef enum logic [1:0] {bw_slow, bw_medium, bw_fast} bw_t;
  typedef enum logic {sliding_mean_mode, block_mean_mode} avg_mode_t;
endpackage

/* File: reading_front_end_model.sv */
// Behavioural front end that offers converter readings to the filter.
`timescale 1ns/1ns
module reading_front_end_model (
  input wire logic clk,
  input wire logic ce,
  input wire logic in_ready,
  output logic in_valid,
  output logic signed [23:0] in_data
);
  logic signed [23:0] last_r;
  initial begin
    in_valid = 1'b0;
    in_data = 24'h000000;
    last_r = 24'h000000;
  end
  // The reading is held until taken, so a settling stall loses nothing.
  task automatic send(input logic signed [23:0] d);
    in_valid <= 1'b1;
    in_data <= d;
    last_r = d;
    do @(posedge clk); while (!(in_ready === 1'b1 && ce === 1'b1));
  endtask
  // An idle line shows the inverse of the last reading, never a stale copy.
  task automatic idle();
    in_valid <= 1'b0;
    in_data <= ~last_r;
  endtask
endmodule

/* File: tb.sv */
// Self-checking testbench of the reading filter and its configuration.
`timescale 1ns/1ns
`include "reading_filter_consts.svh"
module tb;
  import reading_filter_pkg::*;
  logic clk, resetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, in_valid, in_ready;
  logic out_valid, filter_active_indicator, ac_bw_apply, high_z_sel;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, lfsr_r, eo;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic signed [23:0] in_data, out_data;
  logic [2:0] range_sel;
  func_t func;
  res_t conv_res, disp_res;
  bw_t ac_bw;
  logic [31:0] oq[$], rq[$], bq[$];
  int sq[$];
  int error_cnt, tests_run, depth_m, func_m, n;
  logic en_m, mode_m;
  int cy[3] = '{20, 10, 5};
  int dg[3] = '{3, 4, 1};
  reading_average_filter_config #(.W(24), .SLOW_CYC(20), .MED_CYC(10),
    .FAST_CYC(5)) u_dut (.clk, .resetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .in_valid, .in_ready, .in_data, .out_valid, .out_data,
    .filter_active_indicator, .func, .range_sel, .conv_res, .disp_res,
    .ac_bw, .ac_bw_apply, .high_z_sel);
  reading_front_end_model u_fe (.clk, .ce, .in_ready, .in_valid, .in_data);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction
  // Reference mean; integer division truncates toward zero like the design.
  task automatic note(input int d);
    int s;
    s = 0;
    if (!en_m || func_m inside {6, 7, 8, 9}) oq.push_back(d);
    else if (!mode_m) begin
      if (sq.size() == 0) repeat (depth_m) sq.push_back(d);
      else void'(sq.pop_front());
      if (sq.size() < depth_m) sq.push_back(d);
      foreach (sq[i]) s += sq[i];
      oq.push_back(s / depth_m);
    end else begin
      sq.push_back(d);
      foreach (sq[i]) s += sq[i];
      if (sq.size() == depth_m) oq.push_back(s / depth_m);
      if (sq.size() == depth_m) sq.delete();
    end
  endtask
  task automatic feed(input int k);
    logic signed [23:0] d;
    @(posedge clk);
    repeat (k) begin
      lfsr_r = lfsr_next(lfsr_r);
      d = lfsr_r[23:0];
      note(int'(d));
      u_fe.send(d);
    end
    u_fe.idle();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    bq.push_back(32'(r));
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      pa = pa && s_axi_awready !== 1'b1;
      pw = pw && s_axi_wready !== 1'b1;
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    s_axi_bready <= 1'b0;
    // Configuration reaches the outputs and the store a cycle later.
    repeat (3) @(posedge clk);
  endtask
  task automatic rdr(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  task automatic cfg(input logic [7:0] a, input logic [31:0] d);
    logic ne, ch;
    ne = d[3] ? !en_m : d[0];
    ch = 1'b0;
    wr(a, d, 2'b00);
    if (a == `OFS_CTRL) ch = ne != en_m || d[1] != mode_m;
    if (a == `OFS_CTRL) en_m = ne;
    if (a == `OFS_CTRL) mode_m = d[1];
    if (a == `OFS_DEPTH) ch = d != depth_m;
    if (a == `OFS_DEPTH) depth_m = d;
    if (a == `OFS_FUNC) ch = d[3:0] != func_m;
    if (a == `OFS_FUNC) func_m = d[3:0];
    if (ch) sq.delete();
  endtask
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  always @(posedge clk) begin
    if (out_valid === 1'b1) begin
      eo = oq.size() ? oq.pop_front() : 32'h00000BAD;
      check("out", 32'(out_data), eo);
    end
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      check("rdata", s_axi_rdata, rq.pop_front());
      check("rresp", 32'(s_axi_rresp), 32'h0);
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      check("bresp", 32'(s_axi_bresp), bq.pop_front());
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
  initial begin
    {ce, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'b10000;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    lfsr_r = 32'h4CB8;
    {en_m, mode_m, depth_m, func_m} = {2'b10, 32'd10, 32'd0};
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    check("ind", 32'(filter_active_indicator), 32'h1);
    check("hz", 32'(high_z_sel), 32'h0);
    rdr(`OFS_CTRL, 32'h1);
    rdr(`OFS_DEPTH, 32'hA);
    rdr(`OFS_BW, 32'h1);
    rdr(`OFS_RES, 32'h3);
    done("reset");
    feed(15);
    // Readings offered while the clock enable is low must wait, not repeat.
    @(posedge clk);
    ce <= 1'b0;
    fork
      feed(2);
      begin
        repeat (3) @(posedge clk);
        ce <= 1'b1;
      end
    join
    wr(`OFS_DEPTH, 32'h1, 2'b10);
    wr(`OFS_DEPTH, 32'h65, 2'b10);
    rdr(`OFS_DEPTH, 32'hA);
    cfg(`OFS_DEPTH, 32'h64);
    feed(3);
    cfg(`OFS_DEPTH, 32'h2);
    cfg(`OFS_CTRL, 32'h3);
    feed(6);
    for (int f = 6; f < 10; f++) begin
      cfg(`OFS_FUNC, 32'(f));
      feed(2);
    end
    cfg(`OFS_FUNC, 32'h0);
    for (int t = 0; t < 2; t++) begin
      cfg(`OFS_CTRL, 32'h8);
      check("ind", 32'(filter_active_indicator), 32'(t));
      feed(3);
    end
    done("averaging");
    cfg(`OFS_FUNC, 32'h1);
    check("apply", 32'(ac_bw_apply), 32'h1);
    check("conv6", 32'(conv_res inside {fast_6d5, slow_6d5}), 32'h1);
    for (int b = 0; b < 3; b++) begin
      cfg(`OFS_BW, 32'(b));
      check("bw", 32'(ac_bw), 32'(b));
      feed(1);
      n = 0;
      while (out_valid !== 1'b1 && n < 60) begin
        @(posedge clk);
        n++;
        if (n == 1) check("stall", 32'(in_ready), 32'h0);
      end
      check("settle", 32'(n >= cy[b] && n <= cy[b] + 2), 32'h1);
    end
    cfg(`OFS_FUNC, 32'h0);
    check("apply", 32'(ac_bw_apply), 32'h0);
    wr(`OFS_BW, 32'h3, 2'b10);
    done("ac");
    wr(`OFS_RES, 32'h0, 2'b00);
    cfg(`OFS_FUNC, 32'h4);
    wr(`OFS_RES, 32'h5, 2'b00);
    wr(`OFS_RES, 32'h6, 2'b10);
    cfg(`OFS_FUNC, 32'h0);
    rdr(`OFS_RES, 32'h0);
    check("disp", 32'(disp_res), 32'(fast_4d5));
    wr(`OFS_RES, 32'h1, 2'b00);
    for (int i = 0; i < 3; i++) begin
      wr(`OFS_CTRL, 32'h21, 2'b00);
      rdr(`OFS_RES, 32'(dg[i]));
    end
    wr(`OFS_CTRL, 32'h11, 2'b00);
    cfg(`OFS_FUNC, 32'h4);
    rdr(`OFS_RES, 32'h3);
    cfg(`OFS_FUNC, 32'h6);
    wr(`OFS_RES, 32'h4, 2'b10);
    wr(`OFS_RES, 32'h5, 2'b00);
    done("resolution");
    cfg(`OFS_FUNC, 32'h0);
    check("hz", 32'(high_z_sel), 32'h0);
    wr(`OFS_CTRL, 32'h5, 2'b00);
    for (int r = 0; r < 4; r++) begin
      cfg(`OFS_FUNC, 32'(r << 4));
      check("hz", 32'(high_z_sel), 32'(r < 3));
      check("range", 32'(range_sel), 32'(r));
      if (r == 0) rdr(`OFS_STATUS, 32'h3);
    end
    cfg(`OFS_FUNC, 32'h1);
    check("hz", 32'(high_z_sel), 32'h0);
    check("func", 32'(func), 32'h1);
    check("left", 32'(oq.size()), 32'h0);
    done("impedance");
    finish_test();
  end
endmodule
